// ==== verilog/lsc_pkg.sv ====
/*
  Shared constants for the LED driver serial configuration registers: frame layout,
  register addresses, field positions, reset values, write masks and dimming rates.
  Assumes a 100 MHz system clock and 16-bit serial frames, most significant bit first.
*/
// Behaviour
// - frames whose clock count is not a multiple of 16 are rejected, clock fault flagged
// - frames failing parity are rejected and set a sticky parity fault flag
// - bad address write, write in reset to other than the interface register, or nonzero read data set access fault
// - reset pin seen flag latches; read clears it only after reset is released
// - in chain mode the format bit picks address or status in returned frames
// - four pull enables reset to one; writing zero turns each one off
// - configuration source bit zero uses pin defaults, one uses register contents
// - with register configuration, dim source bits choose pin or register duty
// - with register configuration, switch enable bits turn each channel on
// - with register configuration, three-bit rate code selects the common dimming rate from fixed table
// - two-bit threshold code selects short limit 0x0A, 0x14, 0x1F or 0x29
// - short flagged only while output active and reading at or below limit
// - current level sets reference as full scale times code over 127
// - combined interface error is the OR of the three fault flags
// - interface register survives reset pin and accepts writes during it
package lsc_pkg;
  localparam int FR_BITS = 16;
  localparam int FR_ADDR_MSB = 15;
  localparam int FR_ADDR_LSB = 12;
  localparam int FR_WR_BIT = 11;
  localparam int FR_DATA_MSB = 9;
  localparam int FR_STAT_MSB = 15;
  localparam int FR_STAT_LSB = 12;

  localparam logic [3:0] ADDR_NOOP = 4'h0;
  localparam logic [3:0] ADDR_IFCFG = 4'h1;
  localparam logic [3:0] ADDR_GEN = 4'h2;
  localparam logic [3:0] ADDR_CUR1 = 4'h3;

  // interface register: flags in [9:6], config in [5:0]
  localparam int FLAG_CLK = 3;
  localparam int FLAG_PAR = 2;
  localparam int FLAG_ACC = 1;
  localparam int FLAG_HWR = 0;
  localparam int IF_CHAIN = 5;
  localparam int IF_FMT = 4;
  localparam int IF_PULL_MSB = 3;
  localparam logic [5:0] IF_CFG_RESET = 6'h0F;
  localparam logic [3:0] IF_FLAG_RESET = 4'h0;

  localparam int GEN_SRC = 8;
  localparam int GEN_DIM1 = 7;
  localparam int GEN_DIM2 = 6;
  localparam int GEN_SW1 = 5;
  localparam int GEN_SW2 = 4;
  localparam int GEN_RATE_MSB = 2;
  localparam logic [9:0] GEN_RESET = 10'h000;
  localparam logic [9:0] GEN_WMASK = 10'h1F7;

  localparam int CUR_THR_MSB = 9;
  localparam int CUR_THR_LSB = 8;
  localparam int CUR_LVL_MSB = 6;
  localparam logic [9:0] CUR_RESET = 10'h000;
  localparam logic [9:0] CUR_WMASK = 10'h37F;

  localparam logic [3:0] SDO_TEST = 4'h9;
  localparam logic [2:0] RATE_DEFAULT = 3'h0;

  localparam logic [7:0] SHORT_LIM0 = 8'h0A;
  localparam logic [7:0] SHORT_LIM1 = 8'h14;
  localparam logic [7:0] SHORT_LIM2 = 8'h1F;
  localparam logic [7:0] SHORT_LIM3 = 8'h29;

  localparam int RATE_HZ0 = 200;
  localparam int RATE_HZ1 = 333;
  localparam int RATE_HZ2 = 400;
  localparam int RATE_HZ3 = 500;
  localparam int RATE_HZ4 = 667;
  localparam int RATE_HZ5 = 1000;
  localparam int RATE_HZ6 = 2000;
  localparam int RATE_HZ7 = 200;

  localparam int FULL_SCALE_MV = 1250;
  localparam int LEVEL_MAX = 127;
  localparam int CLK_HZ_DEFAULT = 100_000_000;

  function automatic logic [7:0] short_limit(input logic [1:0] code);
    unique case (code)
      2'h0: short_limit = SHORT_LIM0;
      2'h1: short_limit = SHORT_LIM1;
      2'h2: short_limit = SHORT_LIM2;
      2'h3: short_limit = SHORT_LIM3;
    endcase
  endfunction : short_limit

  function automatic int rate_hz(input logic [2:0] code);
    unique case (code)
      3'h0: rate_hz = RATE_HZ0;
      3'h1: rate_hz = RATE_HZ1;
      3'h2: rate_hz = RATE_HZ2;
      3'h3: rate_hz = RATE_HZ3;
      3'h4: rate_hz = RATE_HZ4;
      3'h5: rate_hz = RATE_HZ5;
      3'h6: rate_hz = RATE_HZ6;
      3'h7: rate_hz = RATE_HZ7;
    endcase
  endfunction : rate_hz
endpackage : lsc_pkg

// ==== verilog/lsc_frame_if.sv ====
/*
  Carrier between the serial front end and the register logic.
  Assumes both ends run on the same system clock.
*/
interface lsc_frame_if;
  logic frame_done;
  logic count_ok;
  logic [15:0] frame;
  logic [15:0] resp;
  modport phy(output frame_done, output count_ok, output frame, input resp);
  modport regs(input frame_done, input count_ok, input frame, output resp);
endinterface : lsc_frame_if

// ==== verilog/lsc_spi_phy.sv ====
/*
  Serial front end: synchronises the pins, shifts frames in on rising clock edges and
  the answer out on falling edges, and counts clocks per select window.
  Assumes the serial clock idles low and is far slower than the system clock.
*/
module lsc_spi_phy (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  lsc_frame_if.phy bus
);
  import lsc_pkg::*;

  logic [2:0] sclk_s_q;
  logic [2:0] csn_s_q;
  logic [1:0] sdi_s_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [3:0] cnt_q;
  logic any_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic active;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s_q <= 3'h0;
      csn_s_q <= 3'h7;
      sdi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      csn_s_q <= {csn_s_q[1:0], select_n};
      sdi_s_q <= {sdi_s_q[0], sdi};
    end
  end

  assign active = !csn_s_q[1];
  assign rise = active && sclk_s_q[1] && !sclk_s_q[2];
  assign fall = active && !sclk_s_q[1] && sclk_s_q[2];
  assign cs_fall = !csn_s_q[1] && csn_s_q[2];
  assign cs_rise = csn_s_q[1] && !csn_s_q[2];

  // receive and clock count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 16'h0000;
      cnt_q <= 4'h0;
      any_q <= 1'b0;
    end else if (cs_fall) begin
      cnt_q <= 4'h0;
      any_q <= 1'b0;
    end else if (rise) begin
      rx_q <= {rx_q[14:0], sdi_s_q[1]};
      cnt_q <= cnt_q + 4'h1;
      any_q <= 1'b1;
    end
  end

  // answer shift; bits received earlier pass on for chained devices
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 16'h0000;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= active;
      if (cs_fall) begin
        tx_q <= bus.resp;
        sdo <= bus.resp[FR_BITS-1];
      end else if (fall) begin
        tx_q <= {tx_q[14:0], rx_q[0]};
        sdo <= tx_q[14];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus.frame_done <= 1'b0;
      bus.count_ok <= 1'b0;
      bus.frame <= 16'h0000;
    end else begin
      bus.frame_done <= cs_rise;
      bus.count_ok <= any_q && (cnt_q == 4'h0);
      bus.frame <= rx_q;
    end
  end
endmodule : lsc_spi_phy

// ==== verilog/lsc_config_regs.sv ====
/*
  Configuration registers of a two-channel LED buck controller behind a serial port:
  interface status/config, general config and channel 1 current/short threshold.
  Assumes an active-low reset pin from the board and an 8-bit channel 1 voltage reading
  and output-active level from logic on the same clock.
*/
module lsc_config_regs #(
  parameter int CLK_HZ = lsc_pkg::CLK_HZ_DEFAULT,
  parameter logic [5:0] REV_ID = 6'h00 // arbitrary value
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hw_reset_n,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic [1:0] ch_enable_pin,
  input wire logic ch1_output,
  input wire logic [7:0] ch1_output_voltage_reading,
  output logic reset_pin_pullup_en,
  output logic select_pin_pullup_en,
  output logic serial_clock_pulldown_en,
  output logic serial_in_pulldown_en,
  output logic ch1_dim_source,
  output logic ch2_dim_source,
  output logic ch1_switch_enable,
  output logic ch2_switch_enable,
  output logic [2:0] dim_rate_select,
  output logic dim_tick,
  output logic ch1_short,
  output logic [6:0] ch1_current_level,
  output logic [10:0] ch1_vref_mv,
  output logic spi_error
);
  import lsc_pkg::*;

  lsc_frame_if fif();

  lsc_spi_phy u_phy (
    .clock(clock),
    .rstn(rstn),
    .sclk(sclk),
    .select_n(select_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .bus(fif.phy)
  );

  logic [1:0] hwr_s_q;
  logic [1:0] en_s1_q;
  logic [1:0] en_s2_q;
  logic [3:0] flags_q;
  logic [5:0] ifcfg_q;
  logic [9:0] gen_q;
  logic [9:0] cur_q;
  logic [15:0] resp_q;
  logic [31:0] div_q;
  logic rst_active;
  logic [3:0] f_addr;
  logic f_wr;
  logic [9:0] f_data;
  logic f_good;
  logic wr_ok;
  logic rd_ok;
  logic acc_err;
  logic rd_clr;
  logic [9:0] rd_val;
  logic [3:0] status;
  logic cfg_src;
  logic [31:0] period;

  // pin synchronisers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hwr_s_q <= 2'h3;
      en_s1_q <= 2'h0;
      en_s2_q <= 2'h0;
    end else begin
      hwr_s_q <= {hwr_s_q[0], hw_reset_n};
      en_s1_q <= ch_enable_pin;
      en_s2_q <= en_s1_q;
    end
  end

  assign rst_active = !hwr_s_q[1];
  assign fif.resp = resp_q;
  assign cfg_src = gen_q[GEN_SRC];

  // frame decode
  always_comb begin
    f_addr = fif.frame[FR_ADDR_MSB:FR_ADDR_LSB];
    f_wr = fif.frame[FR_WR_BIT];
    f_data = fif.frame[FR_DATA_MSB:0];
    f_good = fif.frame_done && fif.count_ok && (^fif.frame);
    wr_ok = f_good && f_wr && (f_addr <= ADDR_CUR1)
      && (!rst_active || f_addr == ADDR_IFCFG);
    rd_ok = f_good && !f_wr && (f_data == 10'h000);
    acc_err = f_good && !wr_ok && !rd_ok;
    rd_clr = rd_ok && (f_addr == ADDR_IFCFG);
    unique case (f_addr)
      ADDR_NOOP: rd_val = {REV_ID, SDO_TEST};
      ADDR_IFCFG: rd_val = {flags_q, ifcfg_q};
      ADDR_GEN: rd_val = gen_q;
      ADDR_CUR1: rd_val = cur_q;
      default: rd_val = 10'h000;
    endcase
    status = {spi_error, flags_q[FLAG_HWR], ch1_short, 1'b0};
  end

  // sticky flags, set wins over clear-on-read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags_q <= IF_FLAG_RESET;
    end else begin
      flags_q[FLAG_CLK] <= (flags_q[FLAG_CLK] && !rd_clr)
        || (fif.frame_done && !fif.count_ok);
      flags_q[FLAG_PAR] <= (flags_q[FLAG_PAR] && !rd_clr)
        || (fif.frame_done && fif.count_ok && !(^fif.frame));
      flags_q[FLAG_ACC] <= (flags_q[FLAG_ACC] && !rd_clr) || acc_err;
      flags_q[FLAG_HWR] <= (flags_q[FLAG_HWR] && !rd_clr) || rst_active;
    end
  end

  // interface config: untouched by the reset pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ifcfg_q <= IF_CFG_RESET;
    end else if (wr_ok && f_addr == ADDR_IFCFG) begin
      ifcfg_q <= f_data[IF_CHAIN:0];
    end
  end

  // general and current registers return to defaults under the reset pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gen_q <= GEN_RESET;
      cur_q <= CUR_RESET;
    end else if (rst_active) begin
      gen_q <= GEN_RESET;
      cur_q <= CUR_RESET;
    end else if (wr_ok && f_addr == ADDR_GEN) begin
      gen_q <= f_data & GEN_WMASK;
    end else if (wr_ok && f_addr == ADDR_CUR1) begin
      cur_q <= f_data & CUR_WMASK;
    end
  end

  // answer for the next frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      resp_q <= 16'h0000;
    end else if (fif.frame_done) begin
      if (ifcfg_q[IF_CHAIN] && ifcfg_q[IF_FMT]) begin
        resp_q <= {status, 2'h0, rd_ok ? rd_val : 10'h000};
      end else begin
        resp_q <= {f_addr, 2'h0, rd_ok ? rd_val : 10'h000};
      end
    end
  end

  // effective controls
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reset_pin_pullup_en <= 1'b1;
      select_pin_pullup_en <= 1'b1;
      serial_clock_pulldown_en <= 1'b1;
      serial_in_pulldown_en <= 1'b1;
      ch1_dim_source <= 1'b0;
      ch2_dim_source <= 1'b0;
      ch1_switch_enable <= 1'b0;
      ch2_switch_enable <= 1'b0;
      dim_rate_select <= RATE_DEFAULT;
      ch1_current_level <= 7'h00;
      spi_error <= 1'b0;
    end else begin
      {reset_pin_pullup_en, select_pin_pullup_en, serial_clock_pulldown_en,
        serial_in_pulldown_en} <= ifcfg_q[IF_PULL_MSB:0];
      ch1_dim_source <= cfg_src && gen_q[GEN_DIM1];
      ch2_dim_source <= cfg_src && gen_q[GEN_DIM2];
      ch1_switch_enable <= cfg_src ? gen_q[GEN_SW1] : en_s2_q[0];
      ch2_switch_enable <= cfg_src ? gen_q[GEN_SW2] : en_s2_q[1];
      dim_rate_select <= cfg_src ? gen_q[GEN_RATE_MSB:0] : RATE_DEFAULT;
      ch1_current_level <= cur_q[CUR_LVL_MSB:0];
      spi_error <= flags_q[FLAG_CLK] || flags_q[FLAG_PAR] || flags_q[FLAG_ACC];
    end
  end

  // common dimming rate divider
  assign period = 32'(CLK_HZ / rate_hz(dim_rate_select));
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_q <= 32'h0000_0000;
      dim_tick <= 1'b0;
    end else if (div_q == 32'h0000_0000 || div_q >= period) begin
      div_q <= period - 32'h0000_0001;
      dim_tick <= 1'b1;
    end else begin
      div_q <= div_q - 32'h0000_0001;
      dim_tick <= 1'b0;
    end
  end

  // short detection and current reference
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ch1_short <= 1'b0;
      ch1_vref_mv <= 11'h000;
    end else begin
      ch1_short <= ch1_output
        && (ch1_output_voltage_reading <= short_limit(cur_q[CUR_THR_MSB:CUR_THR_LSB]));
      ch1_vref_mv <= 11'((FULL_SCALE_MV * int'(cur_q[CUR_LVL_MSB:0])) / LEVEL_MAX);
    end
  end

  chk_clock_fault_set: assert property (@(posedge clock) disable iff (!rstn)
    fif.frame_done && !fif.count_ok |=> flags_q[FLAG_CLK] ##1 spi_error)
    else $error("clock fault not flagged");
  chk_parity_fault_set: assert property (@(posedge clock) disable iff (!rstn)
    fif.frame_done && fif.count_ok && !(^fif.frame) && !rst_active
      |=> flags_q[FLAG_PAR] && $stable(gen_q) && $stable(cur_q) && $stable(ifcfg_q))
    else $error("parity fault not flagged");
  chk_read_data_fault: assert property (@(posedge clock) disable iff (!rstn)
    f_good && !f_wr && f_data != 10'h000 |=> flags_q[FLAG_ACC])
    else $error("nonzero read data not flagged");
  chk_reset_seen_held: assert property (@(posedge clock) disable iff (!rstn)
    rst_active |=> flags_q[FLAG_HWR])
    else $error("reset seen flag not held during reset");
  chk_addr_readback: assert property (@(posedge clock) disable iff (!rstn)
    fif.frame_done && !ifcfg_q[IF_CHAIN] |=> resp_q[FR_STAT_MSB:FR_STAT_LSB] == $past(f_addr))
    else $error("address readback format wrong");
  chk_pull_write: assert property (@(posedge clock) disable iff (!rstn)
    wr_ok && f_addr == ADDR_IFCFG |-> ##2 reset_pin_pullup_en == $past(f_data[IF_PULL_MSB], 2))
    else $error("pull enable not written");
  chk_pin_mode_dim: assert property (@(posedge clock) disable iff (!rstn)
    !cfg_src |=> !ch1_dim_source && !ch2_dim_source && dim_rate_select == RATE_DEFAULT)
    else $error("pin mode not honoured");
  chk_switch_follow: assert property (@(posedge clock) disable iff (!rstn)
    cfg_src |=> ch1_switch_enable == $past(gen_q[GEN_SW1]))
    else $error("switch enable not following register");
  chk_short_detect: assert property (@(posedge clock) disable iff (!rstn)
    !ch1_output |=> !ch1_short)
    else $error("short flagged on inactive output");
  chk_ifcfg_in_reset: assert property (@(posedge clock) disable iff (!rstn)
    rst_active && !wr_ok |=> $stable(ifcfg_q) && gen_q == GEN_RESET)
    else $error("interface config lost in reset");

  chk_clock_fault_refuse: assert property (@(posedge clock) disable iff (!rstn)
    fif.frame_done && !fif.count_ok && !rst_active |=> $stable(gen_q) && $stable(cur_q))
    else $error("clock faulted frame changed a register");
  chk_clock_flag_sticky: assert property (@(posedge clock) disable iff (!rstn)
    flags_q[FLAG_CLK] && !rd_clr |=> flags_q[FLAG_CLK])
    else $error("clock fault flag lost before read");
  chk_reset_write_fault: assert property (@(posedge clock) disable iff (!rstn)
    f_good && f_wr && rst_active && f_addr != ADDR_IFCFG |=> flags_q[FLAG_ACC])
    else $error("write during reset not flagged");
  chk_bad_addr_fault: assert property (@(posedge clock) disable iff (!rstn)
    f_good && f_wr && f_addr > ADDR_CUR1 |=> flags_q[FLAG_ACC])
    else $error("write to unsupported address not flagged");
  chk_reset_seen_clear: assert property (@(posedge clock) disable iff (!rstn)
    rd_clr && !rst_active |=> !flags_q[FLAG_HWR])
    else $error("reset seen flag not cleared by read");
  chk_status_readback: assert property (@(posedge clock) disable iff (!rstn)
    fif.frame_done && ifcfg_q[IF_CHAIN] && ifcfg_q[IF_FMT]
      |=> resp_q[FR_STAT_MSB:FR_STAT_LSB] == $past(status))
    else $error("status readback format wrong");
  chk_ch1_dim_reg: assert property (@(posedge clock) disable iff (!rstn)
    cfg_src |=> ch1_dim_source == $past(gen_q[GEN_DIM1]))
    else $error("channel 1 dim source not following register");
  chk_dim_source_reg: assert property (@(posedge clock) disable iff (!rstn)
    cfg_src |=> ch2_dim_source == $past(gen_q[GEN_DIM2]))
    else $error("channel 2 dim source not following register");
  chk_pin_mode_switch: assert property (@(posedge clock) disable iff (!rstn)
    !cfg_src |=> ch2_switch_enable == $past(en_s2_q[1]))
    else $error("channel 2 switch enable not following pin");
  chk_rate_follow: assert property (@(posedge clock) disable iff (!rstn)
    cfg_src |=> dim_rate_select == $past(gen_q[GEN_RATE_MSB:0]))
    else $error("dimming rate code not following register");
  chk_short_low_reading: assert property (@(posedge clock) disable iff (!rstn)
    ch1_output && ch1_output_voltage_reading <= SHORT_LIM0 |=> ch1_short)
    else $error("short below lowest limit not flagged");
  chk_short_high_reading: assert property (@(posedge clock) disable iff (!rstn)
    ch1_output_voltage_reading > SHORT_LIM3 |=> !ch1_short)
    else $error("short flagged above highest limit");
  chk_vref_zero_code: assert property (@(posedge clock) disable iff (!rstn)
    cur_q[CUR_LVL_MSB:0] == 7'h00 |=> ch1_vref_mv == 11'h000 && ch1_current_level == 7'h00)
    else $error("reference not zero for zero code");
  chk_vref_full_scale: assert property (@(posedge clock) disable iff (!rstn)
    cur_q[CUR_LVL_MSB:0] == 7'h7F |=> ch1_vref_mv == 11'(FULL_SCALE_MV))
    else $error("reference not full scale for top code");
  chk_error_combined_set: assert property (@(posedge clock) disable iff (!rstn)
    flags_q[FLAG_PAR] || flags_q[FLAG_ACC] |=> spi_error)
    else $error("combined error not raised");
  chk_error_combined_clr: assert property (@(posedge clock) disable iff (!rstn)
    !flags_q[FLAG_CLK] && !flags_q[FLAG_PAR] && !flags_q[FLAG_ACC] |=> !spi_error)
    else $error("combined error raised without a fault");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!rstn)
    (gen_q & ~GEN_WMASK) == 10'h000 && (cur_q & ~CUR_WMASK) == 10'h000)
    else $error("reserved bit holds a one");
  chk_ifcfg_write_reset: assert property (@(posedge clock) disable iff (!rstn)
    f_good && f_wr && f_addr == ADDR_IFCFG |=> ifcfg_q == $past(f_data[IF_CHAIN:0]))
    else $error("interface config write not taken");
endmodule : lsc_config_regs

// ==== test/lsc_host_model.sv ====
/*
  Host side serial master for the LED driver configuration registers: mode 0, MSB first.
  Assumes the device samples sdi on rising sclk and presents sdo after falling sclk.
*/
module lsc_host_model (
  input wire logic clock,
  input wire logic sdo,
  output logic sclk,
  output logic select_n,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  import lsc_pkg::*;

  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    sdi = 1'b0;
  end

  // one frame of nclk clocks (at most 16); sclk stands low and sdi is pulled low outside
  task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
    @(negedge clock);
    #1;
    select_n = 1'b0;
    rx = 16'h0000;
    for (int i = 0; i < nclk; i++) begin
      sdi = tx[15 - i];
      #62.5;
      rx = {rx[14:0], sdo};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    select_n = 1'b1;
    sdi = 1'b0;
    #200;
  endtask : xfer
endmodule : lsc_host_model

// ==== test/testbench.sv ====
/*
  Self-checking bench for the configuration registers, driven through the serial host model.
  Assumes ch_enable_pin[0] belongs to channel 1 and the answer arrives in the next frame.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lsc_pkg::*;

  localparam int CLK_HZ_SIM = 400000;
  logic clock, rstn, hw_reset_n, sclk, select_n, sdi, sdo, sdo_oe, ch1_output;
  logic [1:0] ch_enable_pin;
  logic [7:0] ch1_output_voltage_reading;
  logic reset_pin_pullup_en, select_pin_pullup_en, serial_clock_pulldown_en;
  logic serial_in_pulldown_en, ch1_dim_source, ch2_dim_source, ch1_switch_enable;
  logic ch2_switch_enable, dim_tick, ch1_short, spi_error;
  logic [2:0] dim_rate_select;
  logic [6:0] ch1_current_level;
  logic [10:0] ch1_vref_mv;
  logic [6:0] gen_o;
  logic [3:0] pull_o;
  logic [15:0] rx;
  int error_cnt = 0;
  int n_tests = 0;
  assign gen_o = {ch1_dim_source, ch2_dim_source, ch1_switch_enable, ch2_switch_enable,
                  dim_rate_select};
  assign pull_o = {reset_pin_pullup_en, select_pin_pullup_en, serial_clock_pulldown_en,
                   serial_in_pulldown_en};

  lsc_config_regs #(.CLK_HZ(CLK_HZ_SIM), .REV_ID(6'h00)) u_dut (
    .clock(clock), .rstn(rstn), .hw_reset_n(hw_reset_n), .sclk(sclk), .select_n(select_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ch_enable_pin(ch_enable_pin),
    .ch1_output(ch1_output), .ch1_output_voltage_reading(ch1_output_voltage_reading),
    .reset_pin_pullup_en(reset_pin_pullup_en), .select_pin_pullup_en(select_pin_pullup_en),
    .serial_clock_pulldown_en(serial_clock_pulldown_en),
    .serial_in_pulldown_en(serial_in_pulldown_en), .ch1_dim_source(ch1_dim_source),
    .ch2_dim_source(ch2_dim_source), .ch1_switch_enable(ch1_switch_enable),
    .ch2_switch_enable(ch2_switch_enable), .dim_rate_select(dim_rate_select),
    .dim_tick(dim_tick), .ch1_short(ch1_short), .ch1_current_level(ch1_current_level),
    .ch1_vref_mv(ch1_vref_mv), .spi_error(spi_error)
  );
  lsc_host_model u_host (.clock(clock), .sdo(sdo), .sclk(sclk), .select_n(select_n), .sdi(sdi));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] mk(input logic [3:0] a, input logic w, input logic [9:0] d);
    mk = {a, w, ~(^{a, w, d}), d};
  endfunction : mk

  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    u_host.xfer(mk(a, 1'b1, d), 16, rx);
  endtask : wr

  // read frame, then a no-op frame that carries the answer back
  task automatic rd(input logic [3:0] a, input logic [3:0] nib, input logic [9:0] d, string w);
    u_host.xfer(mk(a, 1'b0, 10'h000), 16, rx);
    u_host.xfer(mk(ADDR_NOOP, 1'b0, 10'h000), 16, rx);
    chk(w, {nib, 2'b00, d}, rx);
  endtask : rd

  task automatic set_pins(input logic o, input logic [7:0] v);
    @(negedge clock);
    ch1_output = o;
    ch1_output_voltage_reading = v;
    repeat (4) @(negedge clock);
  endtask : set_pins

  task automatic t_reset;
    chk("pulls", 16'h000F, {12'h000, pull_o});
    chk("gen outs", 16'h0000, {9'h000, gen_o});
    rd(ADDR_NOOP, 4'h0, {6'h00, SDO_TEST}, "noop");
    chk("sdo oe idle", 16'h0000, {15'h0000, sdo_oe});
    rd(ADDR_IFCFG, 4'h1, 10'h00F, "ifcfg first");
    rd(ADDR_IFCFG, 4'h1, 10'h00F, "ifcfg cleared");
    rd(ADDR_GEN, 4'h2, 10'h000, "gen reset");
    rd(ADDR_CUR1, 4'h3, 10'h000, "cur reset");
  endtask : t_reset

  task automatic t_gen;
    wr(ADDR_GEN, 10'h3FF);
    rd(ADDR_GEN, 4'h2, 10'h1F7, "gen mask");
    chk("gen outs reg", 16'h007F, {9'h000, gen_o});
    wr(ADDR_GEN, 10'h100);
    chk("gen outs off", 16'h0000, {9'h000, gen_o});
    @(negedge clock);
    ch_enable_pin = 2'b01;
    wr(ADDR_GEN, 10'h0F7);
    chk("gen outs pin", 16'h0010, {9'h000, gen_o});
    @(negedge clock);
    ch_enable_pin = 2'b10;
    repeat (4) @(negedge clock);
    chk("gen outs pin2", 16'h0008, {9'h000, gen_o});
  endtask : t_gen

  task automatic t_rate;
    int hz[8] = '{200, 333, 400, 500, 667, 1000, 2000, 200};
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_GEN, 10'h100 | 10'(c));
      chk("rate code", 16'(c), {13'h0000, dim_rate_select});
      n = 0;
      @(negedge clock);
      for (int k = 0; k < 3000 && dim_tick !== 1'b1; k++) @(negedge clock);
      do begin
        @(negedge clock);
        n++;
      end while (dim_tick !== 1'b1 && n < 3000);
      chk("tick gap", 16'(CLK_HZ_SIM / hz[c]), 16'(n));
    end
  endtask : t_rate

  task automatic t_cur;
    logic [7:0] lim[4] = '{8'h0A, 8'h14, 8'h1F, 8'h29};
    logic [6:0] lvl[4] = '{7'd127, 7'd1, 7'd64, 7'd100};
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_CUR1, {2'(t), 1'b1, lvl[t]});
      rd(ADDR_CUR1, 4'h3, {2'(t), 1'b0, lvl[t]}, "cur mask");
      chk("level", 16'(lvl[t]), {9'h000, ch1_current_level});
      chk("vref", 16'(FULL_SCALE_MV * lvl[t] / LEVEL_MAX), {5'h00, ch1_vref_mv});
      set_pins(1'b1, lim[t]);
      chk("short at limit", 16'h0001, {15'h0000, ch1_short});
      set_pins(1'b1, lim[t] + 8'h01);
      chk("short above", 16'h0000, {15'h0000, ch1_short});
      set_pins(1'b0, 8'h00);
      chk("short inactive", 16'h0000, {15'h0000, ch1_short});
    end
  endtask : t_cur

  task automatic t_err;
    u_host.xfer(mk(ADDR_GEN, 1'b1, 10'h155), 15, rx);
    chk("spi error", 16'h0001, {15'h0000, spi_error});
    rd(ADDR_IFCFG, 4'h1, 10'h20F, "clock fault");
    chk("spi error clr", 16'h0000, {15'h0000, spi_error});
    u_host.xfer(mk(ADDR_GEN, 1'b1, 10'h155) ^ 16'h0400, 16, rx);
    rd(ADDR_IFCFG, 4'h1, 10'h10F, "parity fault");
    wr(4'h5, 10'h000);
    rd(ADDR_IFCFG, 4'h1, 10'h08F, "bad addr write");
    u_host.xfer(mk(ADDR_GEN, 1'b0, 10'h001), 16, rx);
    rd(ADDR_IFCFG, 4'h1, 10'h08F, "read nonzero");
    rd(ADDR_GEN, 4'h2, 10'h107, "gen kept");
  endtask : t_err

  task automatic t_hwr;
    @(negedge clock);
    hw_reset_n = 1'b0;
    repeat (5) @(negedge clock);
    chk("gen held", 16'h0008, {9'h000, gen_o});
    wr(ADDR_GEN, 10'h1F7);
    wr(ADDR_IFCFG, 10'h000);
    chk("pulls off", 16'h0000, {12'h000, pull_o});
    rd(ADDR_IFCFG, 4'h1, 10'h0C0, "write in reset");
    rd(ADDR_IFCFG, 4'h1, 10'h040, "hw seen held");
    @(negedge clock);
    hw_reset_n = 1'b1;
    repeat (5) @(negedge clock);
    rd(ADDR_IFCFG, 4'h1, 10'h040, "hw seen after");
    rd(ADDR_IFCFG, 4'h1, 10'h000, "hw seen clr");
    rd(ADDR_GEN, 4'h2, 10'h000, "gen after");
  endtask : t_hwr

  task automatic t_chain;
    set_pins(1'b1, 8'h00);
    wr(ADDR_IFCFG, 10'h02F);
    rd(ADDR_GEN, 4'h2, 10'h000, "chain addr");
    wr(ADDR_IFCFG, 10'h01F);
    rd(ADDR_GEN, 4'h2, 10'h000, "fmt no chain");
    wr(ADDR_IFCFG, 10'h03F);
    rd(ADDR_CUR1, 4'h2, 10'h000, "chain status");
    set_pins(1'b0, 8'h00);
  endtask : t_chain

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #600_000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    hw_reset_n = 1'b1;
    ch_enable_pin = 2'b00;
    ch1_output = 1'b0;
    ch1_output_voltage_reading = 8'h00;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_gen();
    t_rate();
    t_cur();
    t_err();
    t_hwr();
    t_chain();
    report_and_stop();
  end
endmodule : testbench
